// ==== common/guest_filter_defines.svh ====
// constants for the guest instruction behaviour filter
`ifndef GUEST_FILTER_DEFINES_SVH
`define GUEST_FILTER_DEFINES_SVH
`define BIT_PE              0
`define BIT_TS              3
`define BIT_PG              31
`define BIT_PAE             5
`define LOW_NIBBLE_W        4
`define PRI_SECONDARY_BIT   31
`define CPL_ZERO            2'h0
`define STAMP_MSR_INDEX     32'h0000_0010
`define CR_RESET            32'h0000_0000
`define DIR_ENTRY_COUNT     4
`endif

// ==== common/guest_filter_pkg.sv ====
// types for the guest instruction behaviour filter
package guest_filter_pkg;
    typedef enum logic [8:0] {
        OP_NONE      = 9'h001,
        OP_CLEAR_TASK_SWITCHED_INSTR      = 9'h002,
        OP_CTX_INV   = 9'h004,
        OP_INTERRUPT_RETURN_INSTR      = 9'h008,
        OP_LOAD_SW   = 9'h010,
        OP_RD_CR     = 9'h020,
        OP_WR_CR0    = 9'h040,
        OP_WR_CR3    = 9'h080,
        OP_MISC      = 9'h100
    } op_class_e;
    typedef enum logic [3:0] {
        RES_NORMAL = 4'h1,
        RES_UD     = 4'h2,
        RES_GP     = 4'h4,
        RES_EXIT   = 4'h8
    } outcome_e;
endpackage : guest_filter_pkg

// ==== hw/guest_instr_behavior_filter.sv ====
// decision logic for privileged instructions executed by a guest
`include "guest_filter_defines.svh"
// Overview of operation
// [RULE_01] task clear unmasked: clear flag, fault if fixed
// [RULE_02] task clear masked, shadow zero: flag unchanged
// [RULE_03] task clear masked and shadow set: exit
// [RULE_04] context invalidate disabled: invalid opcode
// [RULE_05] context invalidate enabled: run or exit
// [RULE_06] secondary controls zero without primary bit
// [RULE_07] no nmi exiting: return unblocks real
// [RULE_08] nmi exiting: return clears virtual blocking only
// [RULE_09] unblocking happens even when return faults
// [RULE_10] load status word keeps masked bits
// [RULE_11] register zero read mixes real, shadow
// [RULE_12] register four read mixes real, shadow
// [RULE_13] nested translation: page base read guest-physical
// [RULE_14] register zero write keeps masked bits
// [RULE_15] unrestricted guest exempts bits zero, 31
// [RULE_16] nested write without extended paging: no access
// [RULE_17] extended paging write loads four entries
// [RULE_18] extended paging: paging, extension, not long
// [RULE_19] register four write keeps masked bits
// [RULE_20] monitor wait: fault above level zero, exit
// [RULE_21] monitor wait skip when conditions met
// [RULE_22] stamp read adds signed offset when enabled
// [RULE_23] decide before any state update
module guest_instr_behavior_filter
    import guest_filter_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic        instr_valid_i,
    input  wire op_class_e   op_class_i,
    input  wire logic [1:0]  current_privilege_level_i,
    input  wire logic [31:0] operand_i,
    input  wire logic        read_cr4_sel_i,
    input  wire logic        misc_monitor_wait_instr_i,
    input  wire logic [31:0] count_reg_i,
    input  wire logic [31:0] primary_ctls_i,
    input  wire logic        context_invalidate_enable_ctl_i,
    input  wire logic        page_invalidate_exit_ctl_i,
    input  wire logic        nmi_exit_ctl_i,
    input  wire logic        virtual_nonmaskable_ctl_i,
    input  wire logic        unrestricted_guest_ctl_i,
    input  wire logic        nested_translation_enable_ctl_i,
    input  wire logic        monitor_wait_exit_ctl_i,
    input  wire logic        interrupt_window_exit_ctl_i,
    input  wire logic        virtual_intr_pending_i,
    input  wire logic        stamp_offset_enable_ctl_i,
    input  wire logic [63:0] stamp_offset_value_i,
    input  wire logic [63:0] cycle_stamp_counter_i,
    input  wire logic        long_mode_enable_bit_i,
    input  wire logic        long_mode_active_bit_i,
    input  wire logic        ts_fixed_one_i,
    input  wire logic [31:0] cr0_fixed0_i,
    input  wire logic [31:0] cr0_fixed1_i,
    input  wire logic [31:0] cr4_fixed0_i,
    input  wire logic [31:0] cr4_fixed1_i,
    input  wire logic [31:0] cr0_owner_mask_i,
    input  wire logic [31:0] cr0_read_shadow_i,
    input  wire logic [31:0] cr4_owner_mask_i,
    input  wire logic [31:0] cr4_read_shadow_i,
    input  wire logic        nmi_block_set_i,
    input  wire logic        interrupt_return_instr_faults_i,
    output logic             done_o,
    output outcome_e         outcome_o,
    output logic [63:0]      result_reg_pair_o,
    output logic             result_guest_phys_o,
    output logic             skip_wait_state_o,
    output logic [31:0]      control_reg_zero_o,
    output logic [31:0]      control_reg_four_o,
    output logic [31:0]      page_base_reg_o,
    output logic             ptr_walk_req_o,
    output logic [31:0]      ptr_walk_addr_o,
    output logic             nmi_blocked_o,
    output logic             vnmi_blocked_o
);
    logic [31:0] cr0_q, cr4_q, cr3_q;
    logic        nmi_blk_q, vnmi_blk_q;
    logic        sec_on, eff_ctx_en, eff_unres;
    logic        pae_paging;
    logic [31:0] cr0_view, cr4_view;
    logic [31:0] cr0_wr_val, cr4_wr_val, load_status_word_instr_val;
    logic        cr0_bad, cr4_bad, load_status_word_instr_bad;
    logic [31:0] chk_mask;
    outcome_e    outcome_d;
    logic        upd_cr0, upd_cr4, upd_cr3;

    // secondary controls forced off when the activation bit is clear
    assign sec_on     = primary_ctls_i[`PRI_SECONDARY_BIT]; // RULE_06
    assign eff_ctx_en = sec_on & context_invalidate_enable_ctl_i; // RULE_06
    assign eff_unres  = sec_on & unrestricted_guest_ctl_i; // RULE_06
    logic eff_nested;
    assign eff_nested = sec_on & nested_translation_enable_ctl_i; // RULE_06

    assign pae_paging = cr0_q[`BIT_PG] & cr4_q[`BIT_PAE] & ~long_mode_active_bit_i; // RULE_18

    assign cr0_view = (cr0_q & ~cr0_owner_mask_i) | (cr0_read_shadow_i & cr0_owner_mask_i); // RULE_11
    assign cr4_view = (cr4_q & ~cr4_owner_mask_i) | (cr4_read_shadow_i & cr4_owner_mask_i); // RULE_12

    // owner-masked bits keep the live value
    assign cr0_wr_val = (cr0_q & cr0_owner_mask_i) | (operand_i & ~cr0_owner_mask_i); // RULE_14
    assign cr4_wr_val = (cr4_q & cr4_owner_mask_i) | (operand_i & ~cr4_owner_mask_i); // RULE_19

    always_comb
    begin
        chk_mask = ~cr0_owner_mask_i;
        if (eff_unres)
        begin
            chk_mask[`BIT_PE] = 1'b0; // RULE_15
            chk_mask[`BIT_PG] = 1'b0; // RULE_15
        end
        cr0_bad = |(chk_mask & ((cr0_fixed0_i & ~cr0_wr_val) | (~cr0_fixed1_i & cr0_wr_val)))
                  | (cr0_wr_val[`BIT_PG] & ~cr0_wr_val[`BIT_PE])
                  | (cr0_wr_val[`BIT_PG] & ~cr4_q[`BIT_PAE] & long_mode_enable_bit_i); // RULE_15
    end

    assign cr4_bad = |(~cr4_owner_mask_i
                       & ((cr4_fixed0_i & ~cr4_wr_val) | (~cr4_fixed1_i & cr4_wr_val))); // RULE_19

    // load status word touches only the low nibble and never clears pe
    always_comb
    begin
        load_status_word_instr_val = cr0_q;
        for (int i = 0; i < `LOW_NIBBLE_W; i++)
        begin
            if (!cr0_owner_mask_i[i])
                load_status_word_instr_val[i] = operand_i[i]; // RULE_10
        end
        if (cr0_q[`BIT_PE])
            load_status_word_instr_val[`BIT_PE] = 1'b1; // RULE_10
        load_status_word_instr_bad = |(~cr0_owner_mask_i[`LOW_NIBBLE_W-1:0]
                     & ((cr0_fixed0_i[`LOW_NIBBLE_W-1:0] & ~load_status_word_instr_val[`LOW_NIBBLE_W-1:0])
                     | (~cr0_fixed1_i[`LOW_NIBBLE_W-1:0] & load_status_word_instr_val[`LOW_NIBBLE_W-1:0])));
    end

    // outcome is decided combinationally so control register state only moves on normal results
    always_comb
    begin
        outcome_d = RES_NORMAL;
        upd_cr0 = 1'b0;
        upd_cr4 = 1'b0;
        upd_cr3 = 1'b0;
        case (op_class_i)
            OP_CLEAR_TASK_SWITCHED_INSTR:
            begin
                if (cr0_owner_mask_i[`BIT_TS] && cr0_read_shadow_i[`BIT_TS])
                    outcome_d = RES_EXIT; // RULE_03
                else if (cr0_owner_mask_i[`BIT_TS])
                    outcome_d = RES_NORMAL; // RULE_02
                else if (ts_fixed_one_i)
                    outcome_d = RES_GP; // RULE_01
                else
                    upd_cr0 = 1'b1; // RULE_01
            end
            OP_CTX_INV:
            begin
                if (!eff_ctx_en)
                    outcome_d = RES_UD; // RULE_04
                else if (page_invalidate_exit_ctl_i)
                    outcome_d = RES_EXIT; // RULE_05
            end
            OP_INTERRUPT_RETURN_INSTR:
                outcome_d = interrupt_return_instr_faults_i ? RES_GP : RES_NORMAL;
            OP_LOAD_SW:
            begin
                if (load_status_word_instr_bad)
                    outcome_d = RES_GP; // RULE_10
                else
                    upd_cr0 = 1'b1;
            end
            OP_WR_CR0:
            begin
                if (read_cr4_sel_i)
                begin
                    if (cr4_bad)
                        outcome_d = RES_GP; // RULE_19
                    else
                        upd_cr4 = 1'b1;
                end
                else if (cr0_bad)
                    outcome_d = RES_GP; // RULE_14
                else
                    upd_cr0 = 1'b1;
            end
            OP_WR_CR3:
                upd_cr3 = 1'b1;
            OP_MISC:
            begin
                if (misc_monitor_wait_instr_i)
                begin
                    if (current_privilege_level_i != `CPL_ZERO)
                        outcome_d = RES_UD; // RULE_20
                    else if (monitor_wait_exit_ctl_i)
                        outcome_d = RES_EXIT; // RULE_20
                end
            end
            default:
                outcome_d = RES_NORMAL;
        endcase
    end

    // control register state moves only when the instruction completes normally
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cr0_q <= `CR_RESET;
            cr4_q <= `CR_RESET;
            cr3_q <= `CR_RESET;
        end
        else if (instr_valid_i && outcome_d == RES_NORMAL) // RULE_23
        begin
            if (upd_cr0)
            begin
                if (op_class_i == OP_CLEAR_TASK_SWITCHED_INSTR)
                    cr0_q[`BIT_TS] <= 1'b0; // RULE_01
                else if (op_class_i == OP_LOAD_SW)
                    cr0_q <= load_status_word_instr_val; // RULE_10
                else
                    cr0_q <= cr0_wr_val; // RULE_14
            end
            if (upd_cr4)
                cr4_q <= cr4_wr_val; // RULE_19
            if (upd_cr3)
                cr3_q <= operand_i;
        end
    end

    // nmi blocking; interrupt_return_instr unblocking applies regardless of its own fault
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            nmi_blk_q  <= 1'b0;
            vnmi_blk_q <= 1'b0;
        end
        else if (instr_valid_i && op_class_i == OP_INTERRUPT_RETURN_INSTR) // RULE_09
        begin
            if (!nmi_exit_ctl_i)
                nmi_blk_q <= 1'b0; // RULE_07
            else if (virtual_nonmaskable_ctl_i)
                vnmi_blk_q <= 1'b0; // RULE_08
        end
        else if (nmi_block_set_i)
        begin
            if (nmi_exit_ctl_i && virtual_nonmaskable_ctl_i)
                vnmi_blk_q <= 1'b1;
            else
                nmi_blk_q <= 1'b1;
        end
    end

    // per-instruction answer, one cycle after the instruction is offered
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            done_o              <= 1'b0;
            outcome_o           <= RES_NORMAL;
            result_reg_pair_o   <= 64'h0;
            result_guest_phys_o <= 1'b0;
            skip_wait_state_o   <= 1'b0;
            ptr_walk_req_o      <= 1'b0;
            ptr_walk_addr_o     <= 32'h0;
        end
        else
        begin
            done_o              <= instr_valid_i;
            outcome_o           <= outcome_d;
            result_guest_phys_o <= 1'b0;
            skip_wait_state_o   <= 1'b0;
            ptr_walk_req_o      <= 1'b0;
            result_reg_pair_o   <= 64'h0;
            if (instr_valid_i && outcome_d == RES_NORMAL)
            begin
                case (op_class_i)
                    OP_RD_CR:
                    begin
                        if (misc_monitor_wait_instr_i)
                        begin
                            result_reg_pair_o   <= {32'h0, cr3_q};
                            result_guest_phys_o <= eff_nested; // RULE_13
                        end
                        else
                            result_reg_pair_o <= {32'h0, read_cr4_sel_i ? cr4_view
                                                                        : cr0_view};
                    end
                    OP_WR_CR3:
                    begin
                        result_guest_phys_o <= eff_nested; // RULE_16
                        // pointer entries are fetched only under extended paging
                        ptr_walk_req_o  <= eff_nested & pae_paging; // RULE_17
                        ptr_walk_addr_o <= operand_i;
                    end
                    OP_MISC:
                    begin
                        if (misc_monitor_wait_instr_i)
                            skip_wait_state_o <= count_reg_i[0]
                                & (~interrupt_window_exit_ctl_i | virtual_intr_pending_i); // RULE_21
                        else if (count_reg_i == `STAMP_MSR_INDEX)
                            result_reg_pair_o <= stamp_offset_enable_ctl_i
                                ? 64'($signed(cycle_stamp_counter_i)
                                      + $signed(stamp_offset_value_i))
                                : cycle_stamp_counter_i; // RULE_22
                    end
                    default:
                        result_reg_pair_o <= 64'h0;
                endcase
            end
        end
    end

    assign control_reg_zero_o = cr0_q;
    assign control_reg_four_o = cr4_q;
    assign page_base_reg_o    = cr3_q;
    assign nmi_blocked_o      = nmi_blk_q;
    assign vnmi_blocked_o     = vnmi_blk_q;

    a_clear_task_switched_instr_exit_case: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_CLEAR_TASK_SWITCHED_INSTR && cr0_owner_mask_i[`BIT_TS]
        && cr0_read_shadow_i[`BIT_TS] |=> outcome_o == RES_EXIT && done_o) // RULE_03
        else $error("task clear with mask and shadow set did not exit");
    a_clear_task_switched_instr_keep_ts: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_CLEAR_TASK_SWITCHED_INSTR && cr0_owner_mask_i[`BIT_TS]
        |=> $stable(cr0_q)) // RULE_02
        else $error("masked task clear changed control register zero");
    a_clear_task_switched_instr_clear_ts: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_CLEAR_TASK_SWITCHED_INSTR && !cr0_owner_mask_i[`BIT_TS]
        && !ts_fixed_one_i |=> !cr0_q[`BIT_TS]) // RULE_01
        else $error("unmasked task clear did not clear the flag");
    a_ctx_inv_ud: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_CTX_INV && !eff_ctx_en
        |=> outcome_o == RES_UD) // RULE_04
        else $error("disabled context invalidate did not fault");
    a_interrupt_return_instr_unblock: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_INTERRUPT_RETURN_INSTR && !nmi_exit_ctl_i
        |=> !nmi_blocked_o) // RULE_09
        else $error("interrupt return left nmi blocked");
    a_exit_no_update: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && outcome_d != RES_NORMAL && op_class_i != OP_INTERRUPT_RETURN_INSTR
        |=> $stable(cr0_q) && $stable(cr4_q)) // RULE_23
        else $error("control registers moved on an exiting or faulting instruction");
    a_monitor_wait_instr_ud: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_MISC && misc_monitor_wait_instr_i
        && current_privilege_level_i != `CPL_ZERO |=> outcome_o == RES_UD) // RULE_20
        else $error("monitor wait above level zero did not fault");
    a_cr4_masked_keep: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        instr_valid_i && op_class_i == OP_WR_CR0 && read_cr4_sel_i
        |=> ((cr4_q ^ $past(cr4_q)) & $past(cr4_owner_mask_i)) == 32'h0) // RULE_19
        else $error("masked control register four bits changed");
endmodule : guest_instr_behavior_filter

// ==== sim/tb.sv ====
// self-checking bench for the guest instruction behaviour filter
module tb import guest_filter_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clock_i, sys_rst_i, instr_valid_i, read_cr4_sel_i, misc_monitor_wait_instr_i;
    logic        context_invalidate_enable_ctl_i, page_invalidate_exit_ctl_i, nmi_exit_ctl_i;
    logic        virtual_nonmaskable_ctl_i, unrestricted_guest_ctl_i;
    logic        nested_translation_enable_ctl_i, monitor_wait_exit_ctl_i;
    logic        interrupt_window_exit_ctl_i, virtual_intr_pending_i, stamp_offset_enable_ctl_i;
    logic        long_mode_enable_bit_i, long_mode_active_bit_i, ts_fixed_one_i;
    logic        nmi_block_set_i, interrupt_return_instr_faults_i;
    logic        done_o, result_guest_phys_o, skip_wait_state_o, ptr_walk_req_o;
    logic        nmi_blocked_o, vnmi_blocked_o;
    logic [1:0]  current_privilege_level_i;
    logic [31:0] operand_i, count_reg_i, primary_ctls_i, cr0_fixed0_i, cr0_fixed1_i;
    logic [31:0] cr4_fixed0_i, cr4_fixed1_i, cr0_owner_mask_i, cr0_read_shadow_i;
    logic [31:0] cr4_owner_mask_i, cr4_read_shadow_i;
    logic [31:0] control_reg_zero_o, control_reg_four_o, page_base_reg_o, ptr_walk_addr_o;
    logic [63:0] stamp_offset_value_i, cycle_stamp_counter_i, result_reg_pair_o;
    op_class_e   op_class_i;
    outcome_e    outcome_o;
    int          miscompares;
    int          n_tests;

    guest_instr_behavior_filter u_dut (.*);

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one instruction offered for a single cycle; results are read mid-cycle once settled
    task automatic run(input op_class_e op, input logic [1:0] sel_mw, input logic [31:0] opnd,
                       input outcome_e exp);
        @(posedge clock_i);
        instr_valid_i <= 1'b1;
        op_class_i <= op;
        {read_cr4_sel_i, misc_monitor_wait_instr_i} <= sel_mw;
        operand_i <= opnd;
        @(posedge clock_i);
        instr_valid_i <= 1'b0;
        op_class_i <= OP_NONE;
        @(negedge clock_i);
        chk(64'(done_o), 64'h1);
        chk(64'(outcome_o), 64'(exp));
    endtask : run

    task automatic pulse_nmi();
        @(posedge clock_i);
        nmi_block_set_i <= 1'b1;
        @(posedge clock_i);
        nmi_block_set_i <= 1'b0;
        @(negedge clock_i);
    endtask : pulse_nmi

    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test

    // generous bound: the sequence needs only about a hundred cycles
    initial
    begin
        repeat (3000) @(posedge clock_i);
        miscompares++;
        finish_test();
    end

    initial
    begin
        {instr_valid_i, read_cr4_sel_i, misc_monitor_wait_instr_i, current_privilege_level_i, operand_i,
         count_reg_i, context_invalidate_enable_ctl_i, page_invalidate_exit_ctl_i,
         nmi_exit_ctl_i, virtual_nonmaskable_ctl_i, unrestricted_guest_ctl_i,
         nested_translation_enable_ctl_i, monitor_wait_exit_ctl_i, interrupt_window_exit_ctl_i,
         virtual_intr_pending_i, stamp_offset_enable_ctl_i, stamp_offset_value_i,
         cycle_stamp_counter_i, long_mode_enable_bit_i, long_mode_active_bit_i, ts_fixed_one_i,
         cr0_fixed0_i, cr4_fixed0_i, cr0_owner_mask_i, cr0_read_shadow_i, cr4_owner_mask_i,
         cr4_read_shadow_i, nmi_block_set_i, interrupt_return_instr_faults_i, miscompares, n_tests} = '0;
        sys_rst_i = 1'b1;
        op_class_i = OP_NONE;
        primary_ctls_i = 32'h8000_0000;
        cr0_fixed1_i = '1;
        cr4_fixed1_i = '1;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(negedge clock_i);
        chk(64'(outcome_o), 64'(RES_NORMAL));
        chk(64'(control_reg_zero_o), 64'h0);
        run(OP_WR_CR0, 2'h0, 32'h9, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h9);
        cr0_read_shadow_i <= 32'h8;
        run(OP_CLEAR_TASK_SWITCHED_INSTR, 2'h0, 32'h0, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h1);
        run(OP_WR_CR0, 2'h0, 32'h9, RES_NORMAL);
        ts_fixed_one_i <= 1'b1;
        run(OP_CLEAR_TASK_SWITCHED_INSTR, 2'h0, 32'h0, RES_GP);
        ts_fixed_one_i <= 1'b0;
        cr0_owner_mask_i <= 32'h8;
        run(OP_CLEAR_TASK_SWITCHED_INSTR, 2'h0, 32'h0, RES_EXIT);
        chk(64'(control_reg_zero_o), 64'h9);
        cr0_read_shadow_i <= 32'hF0;
        run(OP_CLEAR_TASK_SWITCHED_INSTR, 2'h0, 32'h0, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h9);
        cr0_owner_mask_i <= 32'hFF;
        run(OP_RD_CR, 2'h0, 32'h0, RES_NORMAL);
        chk(64'(result_reg_pair_o[31:0]), 64'hF0);
        cr4_owner_mask_i <= 32'h10;
        run(OP_WR_CR0, 2'h2, 32'h30, RES_NORMAL);
        chk(64'(control_reg_four_o), 64'h20);
        cr4_fixed1_i <= 32'hFFFF_FF7F;
        run(OP_WR_CR0, 2'h2, 32'hA0, RES_GP);
        cr4_read_shadow_i <= 32'h11;
        run(OP_RD_CR, 2'h2, 32'h0, RES_NORMAL);
        chk(64'(result_reg_pair_o[31:0]), 64'h30);
        cr0_owner_mask_i <= 32'h2;
        run(OP_WR_CR0, 2'h0, 32'h22, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h20);
        cr0_owner_mask_i <= 32'h0;
        cr0_fixed0_i <= 32'h1;
        run(OP_WR_CR0, 2'h0, 32'h0, RES_GP);
        unrestricted_guest_ctl_i <= 1'b1;
        primary_ctls_i <= 32'h0;
        run(OP_WR_CR0, 2'h0, 32'h0, RES_GP);
        primary_ctls_i <= 32'h8000_0000;
        run(OP_WR_CR0, 2'h0, 32'h0, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h0);
        run(OP_WR_CR0, 2'h0, 32'h8000_0000, RES_GP);
        run(OP_WR_CR0, 2'h2, 32'h0, RES_NORMAL);
        long_mode_enable_bit_i <= 1'b1;
        run(OP_WR_CR0, 2'h0, 32'h8000_0001, RES_GP);
        long_mode_enable_bit_i <= 1'b0;
        run(OP_WR_CR0, 2'h0, 32'h8000_0001, RES_NORMAL);
        run(OP_WR_CR0, 2'h2, 32'h20, RES_NORMAL);
        nested_translation_enable_ctl_i <= 1'b1;
        run(OP_WR_CR3, 2'h0, 32'h0012_3000, RES_NORMAL);
        chk(64'(ptr_walk_req_o), 64'h1);
        chk(64'(ptr_walk_addr_o), 64'h0012_3000);
        long_mode_active_bit_i <= 1'b1;
        run(OP_WR_CR3, 2'h0, 32'h0045_6000, RES_NORMAL);
        chk(64'(ptr_walk_req_o), 64'h0);
        chk(64'(page_base_reg_o), 64'h0045_6000);
        run(OP_RD_CR, 2'h1, 32'h0, RES_NORMAL);
        chk(64'(result_guest_phys_o), 64'h1);
        chk(result_reg_pair_o, 64'h0045_6000);
        nested_translation_enable_ctl_i <= 1'b0;
        run(OP_RD_CR, 2'h1, 32'h0, RES_NORMAL);
        chk(64'(result_guest_phys_o), 64'h0);
        cr0_owner_mask_i <= 32'h4;
        run(OP_LOAD_SW, 2'h0, 32'hE, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h8000_000B);
        cr0_fixed1_i <= 32'hFFFF_FFF7;
        run(OP_LOAD_SW, 2'h0, 32'hA, RES_GP);
        cr0_fixed1_i <= '1;
        run(OP_LOAD_SW, 2'h0, 32'h0, RES_NORMAL);
        chk(64'(control_reg_zero_o), 64'h8000_0001);
        run(OP_CTX_INV, 2'h0, 32'h0, RES_UD);
        context_invalidate_enable_ctl_i <= 1'b1;
        run(OP_CTX_INV, 2'h0, 32'h0, RES_NORMAL);
        page_invalidate_exit_ctl_i <= 1'b1;
        run(OP_CTX_INV, 2'h0, 32'h0, RES_EXIT);
        primary_ctls_i <= 32'h0;
        run(OP_CTX_INV, 2'h0, 32'h0, RES_UD);
        pulse_nmi();
        chk(64'(nmi_blocked_o), 64'h1);
        interrupt_return_instr_faults_i <= 1'b1;
        run(OP_INTERRUPT_RETURN_INSTR, 2'h0, 32'h0, RES_GP);
        chk(64'(nmi_blocked_o), 64'h0);
        pulse_nmi();
        nmi_exit_ctl_i <= 1'b1;
        virtual_nonmaskable_ctl_i <= 1'b1;
        pulse_nmi();
        chk(64'(vnmi_blocked_o), 64'h1);
        run(OP_INTERRUPT_RETURN_INSTR, 2'h0, 32'h0, RES_GP);
        chk(64'(nmi_blocked_o), 64'h1);
        chk(64'(vnmi_blocked_o), 64'h0);
        interrupt_return_instr_faults_i <= 1'b0;
        current_privilege_level_i <= 2'h3;
        monitor_wait_exit_ctl_i <= 1'b1;
        run(OP_MISC, 2'h1, 32'h0, RES_UD);
        current_privilege_level_i <= 2'h0;
        run(OP_MISC, 2'h1, 32'h0, RES_EXIT);
        monitor_wait_exit_ctl_i <= 1'b0;
        // every combination of count bit 0, window exiting and pending interrupt
        for (int k = 0; k < 8; k++)
        begin
            {count_reg_i[0], interrupt_window_exit_ctl_i, virtual_intr_pending_i} <= 3'(k);
            run(OP_MISC, 2'h1, 32'h0, RES_NORMAL);
            chk(64'(skip_wait_state_o), 64'(k[2] & (~k[1] | k[0])));
        end
        count_reg_i <= 32'h10;
        cycle_stamp_counter_i <= 64'h5;
        stamp_offset_value_i <= 64'hFFFF_FFFF_FFFF_FFF0;
        run(OP_MISC, 2'h0, 32'h0, RES_NORMAL);
        chk(result_reg_pair_o, 64'h5);
        stamp_offset_enable_ctl_i <= 1'b1;
        run(OP_MISC, 2'h0, 32'h0, RES_NORMAL);
        chk(result_reg_pair_o, 64'h5 + 64'hFFFF_FFFF_FFFF_FFF0);
        finish_test();
    end
endmodule : tb
